// [src/sar_readout.sv]
// conversion control and serial result readout
// assumes a 100 MHz ref_clk, a host serial clock that may stop,
// a result from the converter core valid at msb ready
`timescale 1ns/1ps
module sar_readout
  import sar_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // conversion trigger, differential or single-ended on the positive leg
  input wire logic conversion_trigger_p,
  input wire logic conversion_trigger_n,
  input wire logic trigger_single_ended,
  // converter core result
  input wire logic [RES_BITS-1:0] sar_result,
  // host serial clock, single-ended input
  input wire logic host_sclk,
  // serial data pair
  output logic serial_data_p,
  output logic serial_data_n,
  // echoed clock pair; positive leg also senses the mode strap
  input wire logic echoed_clock_positive_pin_i,
  output logic echoed_clock_positive_pin_o,
  output logic echoed_clock_positive_pin_oe,
  output logic echoed_serial_clock_n,
  // status
  output logic conv_busy,
  output logic first_result_invalid,
  output logic self_clocked_mode
);

  localparam int A_MSB = MSB_READY_CYC;

  // ----------------------------------------------
  // declarations
  // ----------------------------------------------
  logic [3:0] pin_sync;
  logic trig_p_s;
  logic trig_n_s;
  logic trig_se_s;
  logic echo_pin_s;
  logic trig_level;
  logic trig_prev_reg;
  logic trig_rise;
  sar_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic self_mode_reg;
  logic blank_reg;
  logic tag_reg;
  logic lead_reg;
  logic had_result_reg;
  logic rst_hold_reg;
  sar_word_t word_reg;
  logic load;
  logic deadline_hit;
  logic link_tag_seen;
  logic link_bit;
  logic owned;
  logic data_level;
  logic eclk_level;

  // ----------------------------------------------
  // pin synchronisers
  // ----------------------------------------------
  sar_bit_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({conversion_trigger_p, conversion_trigger_n,
               trigger_single_ended, echoed_clock_positive_pin_i}),
    .sync_out(pin_sync)
  );

  assign trig_p_s = pin_sync[3];
  assign trig_n_s = pin_sync[2];
  assign trig_se_s = pin_sync[1];
  assign echo_pin_s = pin_sync[0];

  // ----------------------------------------------
  // trigger edge
  // ----------------------------------------------
  assign trig_level = trig_se_s ? trig_p_s : (trig_p_s & ~trig_n_s);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_level;
    end
  end

  assign trig_rise = trig_level & ~trig_prev_reg;

  // ----------------------------------------------
  // conversion sequencing
  // ----------------------------------------------
  assign load = (state_reg == ST_CONVERT) && (cnt_reg == CNT_W'(MSB_READY_CYC - 1));
  assign deadline_hit = (state_reg == ST_CONVERT) && (cnt_reg == CNT_W'(BURST_DEADLINE_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_STRAP;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_STRAP: begin
          if (cnt_reg == CNT_W'(STRAP_SETTLE_CYC - 1)) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_IDLE: begin
          if (trig_rise) begin
            state_reg <= ST_CONVERT;
            cnt_reg <= '0;
          end
        end
        ST_CONVERT: begin
          // further trigger edges are not looked at here
          if (load) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conv_busy <= 1'b0;
    end else begin
      conv_busy <= (state_reg == ST_IDLE && trig_rise) || (state_reg == ST_CONVERT && !load);
    end
  end

  // ----------------------------------------------
  // mode strap: sensed with the positive echo leg released
  // ----------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      self_mode_reg <= 1'b0;
    end else if (state_reg == ST_STRAP && cnt_reg == CNT_W'(STRAP_SETTLE_CYC - 1)) begin
      self_mode_reg <= ~echo_pin_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      echoed_clock_positive_pin_oe <= 1'b0;
    end else begin
      echoed_clock_positive_pin_oe <= (state_reg != ST_STRAP) && !self_mode_reg;
    end
  end

  assign self_clocked_mode = self_mode_reg;

  // ----------------------------------------------
  // result hold and hand-over to the link domain
  // ----------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      word_reg <= '{invalid: 1'b1, data: RESULT_RST};
      tag_reg <= 1'b0;
      had_result_reg <= 1'b0;
    end else if (load) begin
      word_reg <= '{invalid: !had_result_reg, data: sar_result};
      tag_reg <= ~tag_reg;
      had_result_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_result_invalid <= 1'b0;
    end else if (load) begin
      first_result_invalid <= !had_result_reg;
    end
  end

  // bit shown before the first falling edge of a word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lead_reg <= 1'b0;
    end else if (load) begin
      lead_reg <= self_mode_reg ? 1'b0 : sar_result[RES_BITS-1];
    end
  end

  // old word is gone from the deadline until the new one is ready
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blank_reg <= 1'b0;
    end else if (load) begin
      blank_reg <= 1'b0;
    end else if (deadline_hit) begin
      blank_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_hold_reg <= 1'b1;
    end else begin
      rst_hold_reg <= 1'b0;
    end
  end

  // ----------------------------------------------
  // link-side shifter
  // ----------------------------------------------
  sar_link_shift u_link (
    .host_sclk(host_sclk),
    .rst_async(rst_hold_reg),
    .self_mode(self_mode_reg),
    .tag_in(tag_reg),
    .word_in(word_reg),
    .tag_seen(link_tag_seen),
    .bit_out(link_bit)
  );

  // ----------------------------------------------
  // pins: data and echoed clock pairs
  // ----------------------------------------------
  // both sides are single-bit flops, so the select cannot glitch on a word
  assign owned = (link_tag_seen == tag_reg);
  assign data_level = blank_reg ? 1'b0 : (owned ? link_bit : lead_reg);
  assign eclk_level = host_sclk & ~self_mode_reg & ~blank_reg;

  assign serial_data_p = data_level;
  assign serial_data_n = ~data_level;
  assign echoed_clock_positive_pin_o = eclk_level;
  assign echoed_serial_clock_n = self_mode_reg ? 1'b0 : ~eclk_level;

  // ----------------------------------------------
  // checks
  // ----------------------------------------------
  sequence s_start;
    state_reg == ST_IDLE && trig_rise;
  endsequence

  sequence s_load;
    load;
  endsequence

  property p_start;
    @(posedge ref_clk) disable iff (sys_rst)
      s_start |=> state_reg == ST_CONVERT && cnt_reg == '0;
  endproperty
  a_start: assert property (p_start) else $error("trigger edge did not start conversion");

  property p_conv_len;
    @(posedge ref_clk) disable iff (sys_rst)
      s_start |-> ##A_MSB s_load;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_ignore;
    @(posedge ref_clk) disable iff (sys_rst)
      state_reg == ST_CONVERT && !load |=> state_reg == ST_CONVERT && cnt_reg == $past(cnt_reg) + 1'b1;
  endproperty
  a_ignore: assert property (p_ignore) else $error("conversion disturbed by trigger");

  property p_first_invalid;
    @(posedge ref_clk) disable iff (sys_rst)
      load && !had_result_reg |=> first_result_invalid && word_reg.invalid;
  endproperty
  a_first_invalid: assert property (p_first_invalid) else $error("first result not flagged");

  property p_later_valid;
    @(posedge ref_clk) disable iff (sys_rst)
      load && had_result_reg |=> !first_result_invalid && !word_reg.invalid;
  endproperty
  a_later_valid: assert property (p_later_valid) else $error("later result flagged invalid");

  property p_blank_out;
    @(posedge ref_clk) disable iff (sys_rst)
      blank_reg |-> !serial_data_p && !echoed_clock_positive_pin_o;
  endproperty
  a_blank_out: assert property (p_blank_out) else $error("pins not zero in blank window");

  property p_blank_start;
    @(posedge ref_clk) disable iff (sys_rst)
      deadline_hit && !load |=> blank_reg;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("blank not set at deadline");

  property p_lead;
    @(posedge ref_clk) disable iff (sys_rst)
      load |=> lead_reg == (!self_mode_reg && $past(sar_result[RES_BITS-1])) && !blank_reg;
  endproperty
  a_lead: assert property (p_lead) else $error("lead bit wrong after result");

  property p_strap_release;
    @(posedge ref_clk) disable iff (sys_rst)
      state_reg == ST_STRAP |-> !echoed_clock_positive_pin_oe;
  endproperty
  a_strap_release: assert property (p_strap_release) else $error("echo leg driven during strap");

endmodule : sar_readout

// [pkg/sar_pkg.sv]
// constants, carriers and states of the converter readout block
// assumes a 100 MHz ref_clk; the host serial clock is a separate domain
package sar_pkg;

  // -----------------------------------------------
  // widths and header
  // -----------------------------------------------
  localparam int RES_BITS = 16;
  localparam int HDR_BITS = 2;
  localparam int FRAME_BITS = RES_BITS + HDR_BITS;
  localparam logic [1:0] HDR_TAIL = 2'h2;
  localparam logic [RES_BITS-1:0] RESULT_RST = 16'h0000;

  // -----------------------------------------------
  // timing
  // -----------------------------------------------
  localparam int REF_PERIOD_PS = 10000;
  localparam int MSB_READY_NS = 100;
  localparam int BURST_DEADLINE_NS = 20;
  localparam int STRAP_SETTLE_CYC = 4;
  localparam int CNT_W = 8;

  function automatic int cyc_floor(input int ns);
    int c;
    c = (ns * 1000) / REF_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_floor

  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  localparam int MSB_READY_CYC = cyc_floor(MSB_READY_NS);
  localparam int BURST_DEADLINE_CYC = cyc_ceil(BURST_DEADLINE_NS);

  // -----------------------------------------------
  // carriers and states
  // -----------------------------------------------
  typedef struct packed {
    logic invalid;
    logic [RES_BITS-1:0] data;
  } sar_word_t;

  typedef enum logic [1:0] {ST_STRAP, ST_IDLE, ST_CONVERT} sar_state_t;

endpackage : sar_pkg

// [src/sar_bit_sync.sv]
// two-stage synchroniser for pin levels entering the ref_clk domain
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module sar_bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : sar_bit_sync

// [src/sar_link_shift.sv]
// serial shifter on the falling edge of the host serial clock
// assumes word, tag and mode are held stable while the host clocks
`timescale 1ns/1ps
module sar_link_shift
  import sar_pkg::*;
(
  // link clock and reset request from ref domain
  input wire logic host_sclk,
  input wire logic rst_async,
  // quasi-static inputs from ref domain
  input wire logic self_mode,
  input wire logic tag_in,
  input wire sar_word_t word_in,
  // link outputs
  output logic tag_seen,
  output logic bit_out
);

  logic [1:0] rst_sync_reg;
  logic link_rst;
  logic tag_seen_reg;
  logic bit_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] frame;
  logic start;

  // ----------------------------------------------
  // reset: asserted at once, released on two clock falls
  // ----------------------------------------------
  always_ff @(negedge host_sclk or posedge rst_async) begin
    if (rst_async) begin
      rst_sync_reg <= 2'h3;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b0};
    end
  end
  assign link_rst = rst_sync_reg[1];

  // ----------------------------------------------
  // frame: self-clocked 10 + data, echoed data below msb
  // ----------------------------------------------
  assign start = (tag_in != tag_seen_reg);
  assign frame = self_mode ? {HDR_TAIL, word_in.data}
                           : {word_in.data[RES_BITS-2:0], 3'h0};

  always_ff @(negedge host_sclk or posedge link_rst) begin
    if (link_rst) begin
      tag_seen_reg <= 1'b0;
    end else begin
      tag_seen_reg <= tag_in;
    end
  end

  // one bit per falling edge, zeros after the word
  always_ff @(negedge host_sclk or posedge link_rst) begin
    if (link_rst) begin
      shift_reg <= '0;
      bit_reg <= 1'b0;
    end else if (start) begin
      shift_reg <= {frame[FRAME_BITS-2:0], 1'b0};
      bit_reg <= frame[FRAME_BITS-1];
    end else begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
      bit_reg <= shift_reg[FRAME_BITS-1];
    end
  end

  assign tag_seen = tag_seen_reg;
  assign bit_out = bit_reg;

  // ----------------------------------------------
  // checks
  // ----------------------------------------------
  sequence s_hdr_tail;
    bit_out ##1 !bit_out;
  endsequence

  property p_hdr_order;
    @(negedge host_sclk) disable iff (link_rst)
      start && self_mode |=> s_hdr_tail;
  endproperty
  a_hdr_order: assert property (p_hdr_order) else $error("header tail not 1 then 0");

  property p_echo_first;
    @(negedge host_sclk) disable iff (link_rst)
      start && !self_mode |=> bit_out == $past(word_in.data[RES_BITS-2]);
  endproperty
  a_echo_first: assert property (p_echo_first) else $error("echoed bit after msb wrong");

  property p_self_msb;
    @(negedge host_sclk) disable iff (link_rst)
      start && self_mode |=> ##2 bit_out == $past(word_in.data[RES_BITS-1], 3);
  endproperty
  a_self_msb: assert property (p_self_msb) else $error("data msb not after header");

endmodule : sar_link_shift

// [testbench/sar_host.sv]
// host model on the far side of the serial link: bursts the clock, shifts in data
// assumes the bench calls burst only once the result is ready
`timescale 1ns/1ps
module sar_host
  import sar_pkg::*;
(
  // link clock
  output logic host_sclk,
  // link inputs
  input wire logic echo_pin,
  input wire logic data_in,
  input wire logic self_mode
);
  // ---------------------------------------------
  // capture
  // ---------------------------------------------
  logic [FRAME_BITS-1:0] cap_reg;
  int rises;

  initial begin
    host_sclk = 1'b0;
    cap_reg = '0;
    rises = 0;
  end

  // echoed mode: shift register clocked by the echo
  always @(posedge echo_pin) begin
    if (!self_mode) begin
      cap_reg <= {cap_reg[FRAME_BITS-2:0], data_in};
      rises <= rises + 1;
    end
  end

  // self-clocked: data moves on falls, so sample on own rises
  always @(posedge host_sclk) begin
    if (self_mode) begin
      cap_reg <= {cap_reg[FRAME_BITS-2:0], data_in};
    end
  end

  // ---------------------------------------------
  // clock bursts, 6 ns period, still between frames
  // ---------------------------------------------
  task automatic burst(input int n);
    rises = 0;
    #1.7;
    for (int i = 0; i < n; i++) begin
      #3 host_sclk = ~host_sclk;
      #3 host_sclk = ~host_sclk;
    end
    #1;
  endtask : burst

  task automatic idle(input logic hi);
    host_sclk = hi;
  endtask : idle
endmodule : sar_host

// [testbench/sar_readout_bench.sv]
// self-checking bench for the readout block in both link modes
// assumes sar_host stands in for the receiving logic
`timescale 1ns/1ps
module sar_readout_bench
  import sar_pkg::*;
;
  // ---------------------------------------------
  // signals and instances
  // ---------------------------------------------
  logic ref_clk, sys_rst, trig_p, trig_n, trig_se, strap;
  logic [RES_BITS-1:0] result;
  logic host_sclk, data_p, data_n, pin_o, pin_oe, echo_n, busy, inval, self_m;
  int mismatches, n_tests, len;
  // strap pin resolves to the pull level while undriven
  wire pin_w = pin_oe ? pin_o : strap;

  sar_readout u_sar_readout (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .conversion_trigger_p(trig_p),
    .conversion_trigger_n(trig_n),
    .trigger_single_ended(trig_se),
    .sar_result(result),
    .host_sclk(host_sclk),
    .serial_data_p(data_p),
    .serial_data_n(data_n),
    .echoed_clock_positive_pin_i(pin_w),
    .echoed_clock_positive_pin_o(pin_o),
    .echoed_clock_positive_pin_oe(pin_oe),
    .echoed_serial_clock_n(echo_n),
    .conv_busy(busy),
    .first_result_invalid(inval),
    .self_clocked_mode(self_m)
  );

  sar_host u_sar_host (
    .host_sclk(host_sclk),
    .echo_pin(pin_w),
    .data_in(data_p),
    .self_mode(~strap)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [FRAME_BITS-1:0] exp, input logic [FRAME_BITS-1:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic do_reset(input logic s);
    strap = s;
    u_sar_host.idle(~s);
    sys_rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check_bit("strap oe", 1'b0, pin_oe);
    repeat (6) @(negedge ref_clk);
    check_bit("mode", ~s, self_m);
    check_bit("flag", 1'b0, inval);
    // releases the link domain reset
    u_sar_host.burst(3);
    @(negedge ref_clk);
  endtask : do_reset

  // trigger, then follow busy; probe clocks the host inside the blank window
  task automatic convert(input logic [RES_BITS-1:0] v, input bit retrig, input bit probe);
    int w;
    w = 0;
    len = 0;
    result = v;
    trig_p = 1'b1;
    repeat (3) @(negedge ref_clk);
    trig_p = 1'b0;
    while (busy !== 1'b1 && w < 20) begin
      @(negedge ref_clk);
      w++;
    end
    while (busy === 1'b1 && len < 40) begin
      if (probe && len > 1) check_bit("blank data", 1'b0, data_p);
      if (probe && len > 2 && len < 6) check_bit("blank echo", 1'b0, pin_w);
      if (probe) u_sar_host.idle(len > 1 && len < 6);
      trig_p = retrig && len > 1 && len < 5;
      @(negedge ref_clk);
      len++;
    end
  endtask : convert

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_echo_word;
    do_reset(1'b1);
    convert(16'hA5C3, 1'b0, 1'b0);
    check_word("span", 18'(MSB_READY_CYC), 18'(len));
    check_bit("first flag", 1'b1, inval);
    check_bit("lead", 1'b1, data_p);
    check_bit("data pair", 1'b0, data_n);
    check_bit("echo pair", 1'b1, echo_n);
    u_sar_host.burst(RES_BITS);
    check_word("echo word", 18'(16'hA5C3), 18'(u_sar_host.cap_reg[RES_BITS-1:0]));
    check_word("echo rises", 18'(RES_BITS), 18'(u_sar_host.rises));
    check_bit("after word", 1'b0, data_p);
  endtask : t_echo_word

  task automatic t_echo_blank;
    convert(16'h8001, 1'b0, 1'b0);
    convert(16'h3C5A, 1'b0, 1'b1);
    check_bit("later flag", 1'b0, inval);
    u_sar_host.burst(RES_BITS);
    check_word("new word", 18'(16'h3C5A), 18'(u_sar_host.cap_reg[RES_BITS-1:0]));
  endtask : t_echo_blank

  task automatic t_retrig;
    convert(16'h0F0F, 1'b1, 1'b0);
    check_word("retrig span", 18'(MSB_READY_CYC), 18'(len));
    repeat (5) @(negedge ref_clk);
    check_bit("no extra", 1'b0, busy);
  endtask : t_retrig

  task automatic t_diff;
    trig_se = 1'b0;
    trig_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    trig_p = 1'b1;
    repeat (8) @(negedge ref_clk);
    check_bit("common mode", 1'b0, busy);
    trig_p = 1'b0;
    trig_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    convert(16'h55AA, 1'b0, 1'b0);
    check_word("diff span", 18'(MSB_READY_CYC), 18'(len));
    trig_se = 1'b1;
    trig_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    convert(16'h55AA, 1'b0, 1'b0);
    check_word("single span", 18'(MSB_READY_CYC), 18'(len));
    trig_n = 1'b0;
  endtask : t_diff

  task automatic t_self;
    do_reset(1'b0);
    check_bit("echo drive", 1'b0, pin_oe);
    check_bit("echo neg", 1'b0, echo_n);
    convert(16'h1234, 1'b0, 1'b0);
    check_bit("lead zero", 1'b0, data_p);
    check_bit("first flag again", 1'b1, inval);
    u_sar_host.burst(FRAME_BITS);
    check_word("frame", {HDR_TAIL, 16'h1234}, u_sar_host.cap_reg);
    convert(16'hFEDC, 1'b0, 1'b0);
    u_sar_host.burst(FRAME_BITS);
    check_word("next frame", {HDR_TAIL, 16'hFEDC}, u_sar_host.cap_reg);
  endtask : t_self

  // ---------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------
  initial begin
    mismatches = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    trig_p = 1'b0;
    trig_n = 1'b0;
    trig_se = 1'b1;
    strap = 1'b1;
    result = '0;
    t_echo_word;
    t_echo_blank;
    t_retrig;
    t_diff;
    t_self;
    give_verdict;
  end

  // all scenarios need about 2 us
  initial begin
    #30000;
    mismatches++;
    give_verdict;
  end
endmodule : sar_readout_bench
